// ===== design/bra_pkg.sv
/*
  constants and types shared by the bus release and arbiter block.
  assumes a single system clock; no register bus, control bits are ports.
*/
package bra_pkg;
  // =====================================================================
  // widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CS_W   = 8;
  localparam int MSTP_W = 16;

  // =====================================================================
  // module stop values that halt release in sleep
  localparam logic [15:0] MSTP_ALL_STOP_A = 16'hffff;
  localparam logic [15:0] MSTP_ALL_STOP_B = 16'hefff;

  // =====================================================================
  // reset values
  localparam logic RST_ACK_N  = 1'b1;
  localparam logic RST_DROP_N = 1'b1;

  // external bus ownership states
  typedef enum logic [1:0] {
    BRA_OWNED,      // device drives the external bus
    BRA_RELEASED    // outside master owns the external bus
  } bra_ext_type;

  // internal bus owner
  typedef enum logic [1:0] {
    BRA_IDLE,
    BRA_CPU,
    BRA_XFER
  } bra_own_type;
endpackage : bra_pkg

// ===== design/bra_bus_release_arbiter.sv
/*
  external bus release and internal bus arbiter.
  assumes the bus engine reports cycle boundaries and drives pin values;
  this block decides who owns the bus and gates pin enables.
*/
// Functional notes
// - release only in expansion mode with enable
// - sampled request: acknowledge low, pins floated
// - address, data, selects, strobes all floated
// - internal external access waits during release
// - drop request output when enabled and needed
// - request high ends release, acknowledge high
// - release wins over simultaneous internal access
// - internal bus runs during release
// - release only after current cycle ends
// - sleep with all-stopped value halts release
// - arbiter acknowledges highest priority requester
// - transfer controller above cpu
// - owner keeps bus until acknowledge withdrawn
// - cpu yields only at cycle boundary
// - sleeping cpu yields immediately
// - transfer controller requests on activation
// - transfer controller yields at step ends
// - power-on reset abandons cycle at once
// - manual reset keeps state, finishes cycle
module bra_bus_release_arbiter
  import bra_pkg::*;
(
  // clock and resets
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              clk_en,
  input  wire logic              manual_reset,
  // configuration
  input  wire logic              expansion_mode,
  input  wire logic              release_enable,
  input  wire logic              drop_request_out_enable,
  input  wire logic              sleep_mode,
  input  wire logic [MSTP_W-1:0] module_stop_reg,
  // outside master pins
  input  wire logic              ext_bus_request_n,
  output logic                   ext_bus_ack_n,
  output logic                   drop_request_out_n,
  // pin output enables, high while the device drives
  output logic                   addr_oe,
  output logic                   data_oe,
  output logic                   area_select_oe,
  output logic                   addr_strobe_oe,
  output logic                   read_strobe_oe,
  output logic                   upper_write_strobe_oe,
  output logic                   lower_write_strobe_oe,
  // external bus engine status
  input  wire logic              ext_cycle_busy,
  input  wire logic              ext_cycle_start_req,
  input  wire logic              drive_data,
  output logic                   ext_cycle_go,
  output logic                   wait_ignore,
  // cpu master
  input  wire logic              cpu_req,
  input  wire logic              cpu_cycle_boundary,
  input  wire logic              cpu_split_active,
  output logic                   cpu_ack,
  // transfer controller master
  input  wire logic              xfer_activation,
  input  wire logic              xfer_step_done,
  input  wire logic              xfer_done,
  output logic                   xfer_bus_req,
  output logic                   xfer_ack
);

  // =====================================================================
  // state record
  typedef struct packed {
    logic        req_meta;     // synchroniser stage one
    logic        req_sync;     // synchronised request, active high
    bra_ext_type ext;          // external bus ownership
    bra_own_type own;          // internal bus owner
    logic        xfer_pend;    // transfer controller wants the bus
    logic        ack_n;
    logic        drop_n;
    logic        oe;           // common pin enable
    logic        data_oe;
    logic        go;
    logic        wait_ign;
    logic        cpu_ack;
    logic        xfer_ack;
  } bra_state_type;

  bra_state_type st_reg;   // registered state
  bra_state_type st_next;  // next state

  // =====================================================================
  // helpers
  // release function halted in sleep with all modules stopped
  function automatic logic halt_stop(input logic slp,
                                     input logic [MSTP_W-1:0] m);
    return slp && (m == MSTP_ALL_STOP_A || m == MSTP_ALL_STOP_B);
  endfunction : halt_stop

  logic rel_allowed;   // release may be granted
  logic cpu_can_yield; // cpu sits at a legal hand-over point
  logic want_xfer;     // transfer controller request level

  // =====================================================================
  // next-state logic
  always_comb begin
    st_next       = st_reg;
    rel_allowed   = expansion_mode && release_enable &&
                    !halt_stop(sleep_mode, module_stop_reg);
    // sleeping cpu yields at once, else only at a whole-cycle break
    cpu_can_yield = sleep_mode ||
                    (cpu_cycle_boundary && !cpu_split_active);
    want_xfer     = st_reg.xfer_pend || xfer_activation;

    // the first stage is read only by the second
    st_next.req_meta = !ext_bus_request_n;
    st_next.req_sync = st_reg.req_meta;

    // pending transfer request from activation until done
    if (xfer_activation) begin
      st_next.xfer_pend = 1'b1;
    end else if (xfer_done && st_reg.own == BRA_XFER) begin
      st_next.xfer_pend = 1'b0;
    end

    // -------------------------------------------------------------------
    // external release
    case (st_reg.ext)
      BRA_OWNED: begin
        // a cycle in flight is allowed to end first; the read strobe
        // may thus go from low straight to float
        if (st_reg.req_sync && rel_allowed && !ext_cycle_busy &&
            !srst) begin
          st_next.ext = BRA_RELEASED;
        end
      end
      BRA_RELEASED: begin
        if (!st_reg.req_sync) begin
          st_next.ext = BRA_OWNED;
        end
      end
      default: st_next.ext = BRA_OWNED;
    endcase

    st_next.ack_n   = (st_next.ext != BRA_RELEASED);
    st_next.oe      = (st_next.ext != BRA_RELEASED);
    st_next.data_oe = st_next.oe && drive_data;
    // ask the outside master to let go when internal access waits
    st_next.drop_n  = !(st_next.ext == BRA_RELEASED &&
                        drop_request_out_enable &&
                        ext_cycle_start_req);
    // start external cycles only while owning, release has priority
    st_next.go      = ext_cycle_start_req &&
                      st_next.ext == BRA_OWNED &&
                      !(st_reg.req_sync && rel_allowed);
    // manual reset completes the running cycle without waits
    st_next.wait_ign = manual_reset && ext_cycle_busy;

    // -------------------------------------------------------------------
    // internal arbiter, independent of the external release
    case (st_reg.own)
      BRA_IDLE: begin
        if (want_xfer) begin
          st_next.own = BRA_XFER;
        end else if (cpu_req) begin
          st_next.own = BRA_CPU;
        end
      end
      BRA_CPU: begin
        // cpu holds the bus until the acknowledge is taken back
        if (want_xfer && cpu_can_yield) begin
          st_next.own = BRA_XFER;
        end else if (!cpu_req && cpu_can_yield) begin
          st_next.own = BRA_IDLE;
        end
      end
      BRA_XFER: begin
        // only the end of a vector read, info read, transfer or write
        if (xfer_step_done && (xfer_done || !want_xfer)) begin
          st_next.own = cpu_req ? BRA_CPU : BRA_IDLE;
        end
      end
      default: st_next.own = BRA_IDLE;
    endcase

    // manual reset holds the owner as it is; done before the acknowledges
    // are derived so that they never disagree with the frozen owner
    if (manual_reset) begin
      st_next.own = st_reg.own;
    end

    st_next.cpu_ack  = (st_next.own == BRA_CPU);
    st_next.xfer_ack = (st_next.own == BRA_XFER);
  end

  // =====================================================================
  // state register; power-on reset drops everything at once
  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg          <= '0;
      st_reg.ext      <= BRA_OWNED;
      st_reg.own      <= BRA_IDLE;
      st_reg.ack_n    <= RST_ACK_N;
      st_reg.drop_n   <= RST_DROP_N;
      st_reg.oe       <= 1'b1;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // =====================================================================
  // outputs straight from the state record
  assign ext_bus_ack_n         = st_reg.ack_n;
  assign drop_request_out_n    = st_reg.drop_n;
  assign addr_oe               = st_reg.oe;
  assign data_oe               = st_reg.data_oe;
  assign area_select_oe        = st_reg.oe;
  assign addr_strobe_oe        = st_reg.oe;
  assign read_strobe_oe        = st_reg.oe;
  assign upper_write_strobe_oe = st_reg.oe;
  assign lower_write_strobe_oe = st_reg.oe;
  assign ext_cycle_go          = st_reg.go;
  assign wait_ignore           = st_reg.wait_ign;
  assign cpu_ack               = st_reg.cpu_ack;
  assign xfer_ack              = st_reg.xfer_ack;
  assign xfer_bus_req          = st_reg.xfer_pend;

endmodule : bra_bus_release_arbiter

// ===== tb/bra_props.sv
/* port checks for the bus release and arbiter block.
   assumes one clock, sync srst, clk_en held high by the bench. */
module bra_props
  import bra_pkg::*;
(
  // watched ports, grouped to keep the list short
  input wire logic clock, srst, ext_bus_request_n, ext_bus_ack_n,
  input wire logic drop_request_out_n, drop_request_out_enable, data_oe,
  input wire logic addr_oe, area_select_oe, addr_strobe_oe, read_strobe_oe,
  input wire logic upper_write_strobe_oe, lower_write_strobe_oe,
  input wire logic expansion_mode, release_enable, sleep_mode,
  input wire logic ext_cycle_busy, ext_cycle_start_req, ext_cycle_go,
  input wire logic cpu_ack, cpu_cycle_boundary, cpu_split_active,
  input wire logic xfer_activation, xfer_step_done, xfer_bus_req, xfer_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // =================
  // external release
  chk_pins_float: assert property (
    !ext_bus_ack_n |-> !(addr_oe | data_oe | area_select_oe | addr_strobe_oe
    | read_strobe_oe | upper_write_strobe_oe | lower_write_strobe_oe))
    else $error("bus pins driven while released");
  chk_release_gate: assert property (
    $fell(ext_bus_ack_n) |-> $past(expansion_mode) && $past(release_enable)
    && !$past(ext_cycle_busy)) else $error("release not allowed");
  chk_release_sync: assert property (
    $fell(ext_bus_ack_n) |-> !$past(ext_bus_request_n, 3))
    else $error("release without synced request");
  // reset forces the acknowledge high, so skip the edge after it
  chk_release_end: assert property (
    !$past(srst) && $rose(ext_bus_ack_n) |-> $past(ext_bus_request_n, 3))
    else $error("release ended while requested");
  chk_go_held: assert property (
    !ext_bus_ack_n |-> !ext_cycle_go) else $error("cycle started in release");
  chk_drop_out: assert property (
    !ext_bus_ack_n && ext_cycle_start_req && drop_request_out_enable
    ##1 !ext_bus_ack_n |-> !drop_request_out_n) else $error("no drop ask");
  // =================
  // internal arbiter
  chk_one_owner: assert property (
    !(cpu_ack && xfer_ack)) else $error("two bus owners");
  chk_xfer_first: assert property (
    $rose(cpu_ack) |-> !$past(xfer_bus_req) || $past(xfer_ack))
    else $error("cpu granted over transfer controller");
  chk_cpu_yield: assert property (
    $rose(xfer_ack) && $past(cpu_ack) |-> $past(sleep_mode) ||
    $past(cpu_cycle_boundary) && !$past(cpu_split_active))
    else $error("cpu yielded mid cycle");
  chk_xfer_req: assert property (
    xfer_activation |=> xfer_bus_req || xfer_ack) else $error("no request");
  chk_xfer_yield: assert property (
    !$past(srst) && $fell(xfer_ack) |-> $past(xfer_step_done))
    else $error("transfer controller yielded mid step");
endmodule : bra_props

bind bra_bus_release_arbiter bra_props i_bra_props (.*);

// ===== tb/bra_ext_master.sv
/* outside bus master model driving the request pin.
   assumes the bench raises want; pin has a pull-up so idle is high. */
module bra_ext_master (
  // control from the bench
  input wire logic       clock,
  input wire logic       want,
  input wire logic [3:0] tenure,
  // device pins
  input wire logic       drop_request_out_n,
  input wire logic       ext_bus_ack_n,
  output logic           ext_bus_request_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = '0;  // cycles owned so far
  logic       done = 0;  // tenure over, wait for want to fall
  // request held low for the whole tenure, changed just after the edge
  always @(posedge clock) begin
    if (!want) begin
      ext_bus_request_n <= 1'b1;
      done <= 1'b0;
      cnt <= '0;
    end else if (!done) begin
      if (!ext_bus_ack_n) cnt <= cnt + 4'h1;
      // give up early when the device asks, never before owning once
      if (!ext_bus_ack_n && (cnt == tenure || !drop_request_out_n)) begin
        ext_bus_request_n <= 1'b1;
        done <= 1'b1;
      end else ext_bus_request_n <= 1'b0;
    end
  end
endmodule : bra_ext_master

// ===== tb/bra_bus_release_arbiter_tb.sv
/* self-checking bench for the bus release and arbiter block.
   assumes inputs change at the falling edge; partner drives the pin. */
module bra_bus_release_arbiter_tb import bra_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // =================
  // signals; clk_en and drive_data stay tied
  logic clock = 0, srst = 1, clk_en = 1, manual_reset = 0, drive_data = 1;
  logic expansion_mode = 1, release_enable = 0, drop_request_out_enable = 0;
  logic sleep_mode = 0, ext_cycle_busy = 0, ext_cycle_start_req = 0, want = 0;
  logic cpu_req = 0, cpu_cycle_boundary = 0, cpu_split_active = 0;
  logic xfer_activation = 0, xfer_step_done = 0, xfer_done = 0;
  logic [MSTP_W-1:0] module_stop_reg = 16'h3fff;
  logic [3:0] tenure = 4'hf;
  logic ext_bus_request_n, ext_bus_ack_n, drop_request_out_n, addr_oe, data_oe;
  logic area_select_oe, addr_strobe_oe, read_strobe_oe, upper_write_strobe_oe;
  logic lower_write_strobe_oe, ext_cycle_go, wait_ignore, cpu_ack, xfer_ack;
  logic xfer_bus_req, held_cpu_ack, held_xfer_ack;
  int err_count = 0, n_compared = 0, n;
  bra_bus_release_arbiter i_bra_bus_release_arbiter (.*);
  bra_ext_master i_bra_ext_master (.*);
  initial forever #2 clock = ~clock;
  // =================
  // helpers
  task automatic check(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // bounded wait: 0 acknowledge pin, 1 transfer grant, 2 cycle permission
  task automatic wait_for(input int w, input logic lvl);
    n = 0;
    while ((w == 0 ? ext_bus_ack_n : w == 1 ? xfer_ack : ext_cycle_go)
           !== lvl) begin
      @(negedge clock);
      n++;
      if (n > 40) begin
        err_count++;
        end_of_test();
      end
    end
  endtask : wait_for
  // =================
  // main sequence
  initial begin
    n = $urandom(96296);
    repeat (3) @(negedge clock);
    srst = 0;
    // mode and enable each missing in turn, then sleep with stop values
    for (int i = 0; i < 4; i++) begin
      expansion_mode = i != 0;
      release_enable = i != 1;
      sleep_mode = i > 1;
      module_stop_reg = i == 3 ? MSTP_ALL_STOP_B : MSTP_ALL_STOP_A;
      want = 1;
      repeat (8) @(negedge clock);
      check(ext_bus_ack_n, 1'b1);
      want = 0;
      @(negedge clock);
    end
    // let the synchronised request drain before release is allowed
    repeat (4) @(negedge clock);
    sleep_mode = 0;
    module_stop_reg = 16'h3fff;
    want = 1;
    wait_for(0, 1'b0);
    check(n == 4, 1'b1);
    check(|{addr_oe, data_oe, area_select_oe, addr_strobe_oe, read_strobe_oe,
            upper_write_strobe_oe, lower_write_strobe_oe}, 1'b0);
    ext_cycle_start_req = 1;
    drop_request_out_enable = 1;
    cpu_req = 1;
    @(negedge clock);
    check(drop_request_out_n, 1'b0);
    check(ext_cycle_go, 1'b0);
    check(cpu_ack, 1'b1);
    wait_for(0, 1'b1);
    check(addr_oe, 1'b1);
    wait_for(2, 1'b1);
    ext_cycle_start_req = 0;
    // busy cycle delays the release until it ends
    want = 0;
    ext_cycle_busy = 1;
    @(negedge clock);
    want = 1;
    repeat (8) @(negedge clock);
    check(ext_bus_ack_n, 1'b1);
    ext_cycle_busy = 0;
    wait_for(0, 1'b0);
    check(n == 1, 1'b1);
    want = 0;
    // cpu held mid split access at a boundary, freed by split end or by sleep
    for (int m = 0; m < 2; m++) begin
      cpu_split_active = 1;
      cpu_cycle_boundary = 1;
      xfer_activation = 1;
      @(negedge clock);
      xfer_activation = 0;
      repeat (3) @(negedge clock);
      check(xfer_ack, 1'b0);
      if (m == 1) sleep_mode = 1;
      else cpu_split_active = 0;
      wait_for(1, 1'b1);
      check(n < 3, 1'b1);
      check(cpu_ack, 1'b0);
      xfer_step_done = 1;
      xfer_done = 1;
      @(negedge clock);
      {xfer_step_done, xfer_done, sleep_mode} = 3'h0;
      wait_for(1, 1'b0);
    end
    // random traffic, assertions watch the relations
    repeat (600) begin
      @(negedge clock);
      {cpu_req, cpu_cycle_boundary, cpu_split_active, xfer_step_done,
       xfer_done, ext_cycle_start_req, drop_request_out_enable} = 7'($urandom);
      xfer_activation = $urandom % 8 == 0;
      ext_cycle_busy = $urandom % 4 == 0;
      tenure = 4'($urandom);
      if ($urandom % 16 == 0) want = !want;
      check(cpu_ack & xfer_ack, 1'b0);
    end
    // manual reset freezes the owner and ignores waits of a busy cycle
    held_cpu_ack = cpu_ack;
    held_xfer_ack = xfer_ack;
    {cpu_req, xfer_activation, ext_cycle_busy, xfer_step_done} = 4'h6;
    manual_reset = 1;
    @(negedge clock);
    xfer_activation = 0;
    @(negedge clock);
    check(wait_ignore, 1'b1);
    check(cpu_ack, held_cpu_ack);
    check(xfer_ack, held_xfer_ack);
    manual_reset = 0;
    ext_cycle_busy = 0;
    @(negedge clock);
    check(wait_ignore, 1'b0);
    // reset in mid run drops every grant at once
    srst = 1;
    @(negedge clock);
    check(ext_bus_ack_n & addr_oe & !cpu_ack & !xfer_ack, 1'b1);
    check(data_oe | !drop_request_out_n | ext_cycle_go, 1'b0);
    end_of_test();
  end
endmodule : bra_bus_release_arbiter_tb
